// ==== src/set_features_pkg.sv ====
// constants, types and defaults for the set-features command handler
package set_features_pkg;

    // ------------------------------------------------------------
    // opcode and subcommand codes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_SET_FEATURES = 8'hEF;
    localparam logic [7:0] SF_8BIT_ON       = 8'h01;
    localparam logic [7:0] SF_8BIT_OFF      = 8'h81;
    localparam logic [7:0] SF_WCACHE_ON     = 8'h02;
    localparam logic [7:0] SF_WCACHE_OFF    = 8'h82;
    localparam logic [7:0] SF_XFER_MODE     = 8'h03;
    localparam logic [7:0] SF_APM_ON        = 8'h05;
    localparam logic [7:0] SF_APM_OFF       = 8'h85;
    localparam logic [7:0] SF_EXTPWR_ON     = 8'h09;
    localparam logic [7:0] SF_EXTPWR_OFF    = 8'h89;
    localparam logic [7:0] SF_PL1_ON        = 8'h0A;
    localparam logic [7:0] SF_PL1_OFF       = 8'h8A;
    localparam logic [7:0] SF_LOOKAHEAD_OFF = 8'h55;
    localparam logic [7:0] SF_LOOKAHEAD_ON  = 8'hAA;
    localparam logic [7:0] SF_LONG4         = 8'hBB;
    localparam logic [7:0] SF_REVERT_OFF    = 8'h66;
    localparam logic [7:0] SF_REVERT_ON     = 8'hCC;
    localparam logic [7:0] SF_LEGACY_NOP_A  = 8'h69;
    localparam logic [7:0] SF_LEGACY_NOP_B  = 8'h96;
    localparam logic [7:0] SF_LEGACY_OLD    = 8'h97;
    localparam logic [7:0] SF_CUR_LIMIT     = 8'h9A;

    // ------------------------------------------------------------
    // transfer mode parameter fields
    // ------------------------------------------------------------
    localparam int         XFER_TYPE_MSB = 7;
    localparam int         XFER_TYPE_LSB = 3;
    localparam int         XFER_MODE_MSB = 2;
    localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
    localparam logic [4:0] XT_PIO_FLOW    = 5'h01;
    localparam logic [4:0] XT_MDMA        = 5'h04;
    localparam logic [4:0] XT_UDMA        = 5'h08;
    localparam logic [2:0] XM_IORDY_OFF   = 3'h1;
    localparam logic [2:0] PIO_IORDY_MIN  = 3'h3;

    // ------------------------------------------------------------
    // power management levels
    // ------------------------------------------------------------
    localparam logic [7:0] APM_RSVD_LO = 8'h00;
    localparam logic [7:0] APM_RSVD_HI = 8'hFF;
    localparam logic [7:0] APM_NO_STBY = 8'h80;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] subcommand;
        logic [7:0] param;
    } task_file_t;

    typedef struct packed {
        logic       eight_bit;
        logic       wcache;
        logic [2:0] pio_mode;
        logic       iordy_off;
        logic       dma_udma;
        logic [2:0] dma_mode;
        logic       apm_en;
        logic [7:0] apm_level;
        logic       ext_power;
        logic       pl1_en;
        logic       lookahead;
        logic       long4;
        logic [7:0] cur_limit;
        logic       revert_en;
    } feat_t;

    // ------------------------------------------------------------
    // power-on defaults
    // ------------------------------------------------------------
    localparam feat_t FEAT_DEFAULT = '{
        eight_bit: 1'b0, wcache: 1'b0, pio_mode: 3'h0, iordy_off: 1'b0,
        dma_udma: 1'b0, dma_mode: 3'h0, apm_en: 1'b0, apm_level: 8'hFE,
        ext_power: 1'b0, pl1_en: 1'b0, lookahead: 1'b1, long4: 1'b1,
        cur_limit: 8'hFF, revert_en: 1'b1};

endpackage : set_features_pkg

// ==== src/set_features_handler.sv ====
// set-features command handler: decode, feature state, abort and returns
// Summary of operation
// - decode opcode EFh, subcommand and parameter; abort unsupported or invalid input
// - 8-bit mode: data on low lanes, 16-bit indication never asserted
// - write cache on/off; disabling flushes cache before completion
// - transfer mode: parameter bits 7:3 type, bits 2:0 mode
// - types: 00001 PIO flow, 00100 multiword DMA, 01000 Ultra DMA, 00010 reserved
// - zero selects default PIO; value 1 also disables IORDY if supported
// - exactly one PIO mode and one DMA mode held at all times
// - PIO mode 3 or higher always uses IORDY flow control
// - enabling Ultra DMA clears multiword DMA and vice versa
// - every mode up to the highest supported one is accepted
// - power management enable takes level from parameter, 01h to FEh
// - 80h and up without standby, 02h-7Fh with standby, 00h/FFh reserved
// - valid power levels accepted but change no behaviour
// - power management disable turns it off
// - power level 1 commands on/off, default off
// - defaults: look-ahead on, 4-byte long data; 55h off, AAh on
// - current limit in quarter mA; return min in low, max in high
// - limit defaults to highest performance; out-of-range values clamped
// - revert to defaults on soft reset while idle and no command is taken in that cycle, on/off, on by default
// - legacy codes 69h, 96h, 97h accepted as no-operation
// - extended power operations on/off
module set_features_handler #(
    parameter logic [2:0] PIO_MAX_MODE  = 3'h4,
    parameter logic [2:0] MDMA_MAX_MODE = 3'h2,
    parameter logic [2:0] UDMA_MAX_MODE = 3'h6,
    parameter logic       IORDY_DIS_OK  = 1'b1,
    parameter logic [7:0] CUR_MIN       = 8'h01,
    parameter logic [7:0] CUR_MAX       = 8'hFF
) (
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         cmd_valid,
    input  wire set_features_pkg::task_file_t cmd_tf,
    input  wire logic                         soft_rst,
    input  wire logic                         flush_ack,
    input  wire logic                         data_access,
    output logic                              busy,
    output logic                              cmd_done,
    output logic                              cmd_abort,
    output logic                              ret_load,
    output logic [7:0]                        ret_low,
    output logic [7:0]                        ret_high,
    output logic                              flush_req,
    output logic                              iordy_en,
    output logic                              io16_n,
    output set_features_pkg::feat_t           feat
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CUR_MIN > CUR_MAX)
    begin : g_bad_limit
        $error("current limit minimum above maximum");
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FLUSH = 3'b010,
        ST_DONE  = 3'b100
    } state_t;

    state_t                    state_q;
    state_t                    state_d;
    set_features_pkg::feat_t   feat_q;
    set_features_pkg::feat_t   feat_d;
    logic                      abort_q;
    logic                      abort_d;
    logic                      ret_q;
    logic [7:0]                ret_low_q;
    logic [7:0]                ret_high_q;
    logic                      take;
    logic                      bad;
    logic [4:0]                xtype;
    logic [2:0]                xmode;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic xfer_bad(input logic [7:0] p);
        logic [4:0] t;
        logic [2:0] m;
        t = p[set_features_pkg::XFER_TYPE_MSB:set_features_pkg::XFER_TYPE_LSB];
        m = p[set_features_pkg::XFER_MODE_MSB:0];
        unique case (t)
            set_features_pkg::XT_PIO_DEFAULT:
                xfer_bad = (m > set_features_pkg::XM_IORDY_OFF) ||
                           (m == set_features_pkg::XM_IORDY_OFF && !IORDY_DIS_OK);
            set_features_pkg::XT_PIO_FLOW: xfer_bad = (m > PIO_MAX_MODE);
            set_features_pkg::XT_MDMA:     xfer_bad = (m > MDMA_MAX_MODE);
            set_features_pkg::XT_UDMA:     xfer_bad = (m > UDMA_MAX_MODE);
            default:                       xfer_bad = 1'b1;
        endcase
    endfunction : xfer_bad

    function automatic logic [7:0] clamp_limit(input logic [7:0] v);
        if (v < CUR_MIN)
            clamp_limit = CUR_MIN;
        else if (v > CUR_MAX)
            clamp_limit = CUR_MAX;
        else
            clamp_limit = v;
    endfunction : clamp_limit

    assign take  = cmd_valid && (state_q == ST_IDLE) &&
                   (cmd_tf.opcode == set_features_pkg::OPC_SET_FEATURES);
    assign xtype = cmd_tf.param[set_features_pkg::XFER_TYPE_MSB:
                                set_features_pkg::XFER_TYPE_LSB];
    assign xmode = cmd_tf.param[set_features_pkg::XFER_MODE_MSB:0];

    // ------------------------------------------------------------
    // validity of the subcommand and its parameter
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (cmd_tf.subcommand)
            set_features_pkg::SF_8BIT_ON, set_features_pkg::SF_8BIT_OFF,
            set_features_pkg::SF_WCACHE_ON, set_features_pkg::SF_WCACHE_OFF,
            set_features_pkg::SF_APM_OFF,
            set_features_pkg::SF_EXTPWR_ON, set_features_pkg::SF_EXTPWR_OFF,
            set_features_pkg::SF_PL1_ON, set_features_pkg::SF_PL1_OFF,
            set_features_pkg::SF_LOOKAHEAD_OFF, set_features_pkg::SF_LOOKAHEAD_ON,
            set_features_pkg::SF_LONG4,
            set_features_pkg::SF_REVERT_OFF, set_features_pkg::SF_REVERT_ON,
            set_features_pkg::SF_LEGACY_NOP_A, set_features_pkg::SF_LEGACY_NOP_B,
            set_features_pkg::SF_LEGACY_OLD,
            set_features_pkg::SF_CUR_LIMIT:
                bad = 1'b0;
            set_features_pkg::SF_XFER_MODE:
                bad = xfer_bad(cmd_tf.param);
            set_features_pkg::SF_APM_ON:
                bad = (cmd_tf.param == set_features_pkg::APM_RSVD_LO) ||
                      (cmd_tf.param == set_features_pkg::APM_RSVD_HI);
            default:
                bad = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // next feature state
    // ------------------------------------------------------------
    always_comb
    begin
        feat_d = feat_q;
        if (take && !bad)
        begin
            unique case (cmd_tf.subcommand)
                set_features_pkg::SF_8BIT_ON:       feat_d.eight_bit = 1'b1;
                set_features_pkg::SF_8BIT_OFF:      feat_d.eight_bit = 1'b0;
                set_features_pkg::SF_WCACHE_ON:     feat_d.wcache = 1'b1;
                set_features_pkg::SF_APM_ON:
                begin
                    feat_d.apm_en    = 1'b1;
                    feat_d.apm_level = cmd_tf.param;
                end
                set_features_pkg::SF_APM_OFF:       feat_d.apm_en = 1'b0;
                set_features_pkg::SF_EXTPWR_ON:     feat_d.ext_power = 1'b1;
                set_features_pkg::SF_EXTPWR_OFF:    feat_d.ext_power = 1'b0;
                set_features_pkg::SF_PL1_ON:        feat_d.pl1_en = 1'b1;
                set_features_pkg::SF_PL1_OFF:       feat_d.pl1_en = 1'b0;
                set_features_pkg::SF_LOOKAHEAD_OFF: feat_d.lookahead = 1'b0;
                set_features_pkg::SF_LOOKAHEAD_ON:  feat_d.lookahead = 1'b1;
                set_features_pkg::SF_LONG4:         feat_d.long4 = 1'b1;
                set_features_pkg::SF_REVERT_OFF:    feat_d.revert_en = 1'b0;
                set_features_pkg::SF_REVERT_ON:     feat_d.revert_en = 1'b1;
                set_features_pkg::SF_CUR_LIMIT:
                    feat_d.cur_limit = clamp_limit(cmd_tf.param);
                set_features_pkg::SF_XFER_MODE:
                begin
                    unique case (xtype)
                        set_features_pkg::XT_PIO_DEFAULT:
                        begin
                            feat_d.pio_mode  = set_features_pkg::FEAT_DEFAULT.pio_mode;
                            feat_d.iordy_off = (xmode == set_features_pkg::XM_IORDY_OFF);
                        end
                        set_features_pkg::XT_PIO_FLOW:
                        begin
                            feat_d.pio_mode  = xmode;
                            feat_d.iordy_off = 1'b0;
                        end
                        set_features_pkg::XT_MDMA:
                        begin
                            feat_d.dma_udma = 1'b0;
                            feat_d.dma_mode = xmode;
                        end
                        default:
                        begin
                            feat_d.dma_udma = 1'b1;
                            feat_d.dma_mode = xmode;
                        end
                    endcase
                end
                default:
                    feat_d = feat_q;
            endcase
        end
        if (state_q == ST_FLUSH && flush_ack)
            feat_d.wcache = 1'b0;
        if (soft_rst && feat_q.revert_en && state_q == ST_IDLE && !take)
            feat_d = set_features_pkg::FEAT_DEFAULT;
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        abort_d = abort_q;
        unique case (state_q)
            ST_IDLE:
                if (take)
                begin
                    abort_d = bad;
                    if (!bad && cmd_tf.subcommand == set_features_pkg::SF_WCACHE_OFF)
                        state_d = ST_FLUSH;
                    else
                        state_d = ST_DONE;
                end
            ST_FLUSH:
                if (flush_ack)
                    state_d = ST_DONE;
            ST_DONE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            abort_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            abort_q <= abort_d;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            feat_q <= set_features_pkg::FEAT_DEFAULT;
        else
            feat_q <= feat_d;
    end

    // ------------------------------------------------------------
    // current-limit range return
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ret_q      <= 1'b0;
            ret_low_q  <= 8'h00;
            ret_high_q <= 8'h00;
        end
        else if (take)
        begin
            ret_q <= !bad && (cmd_tf.subcommand == set_features_pkg::SF_CUR_LIMIT);
            if (!bad && cmd_tf.subcommand == set_features_pkg::SF_CUR_LIMIT)
            begin
                ret_low_q  <= CUR_MIN;
                ret_high_q <= CUR_MAX;
            end
        end
        else if (state_q == ST_DONE)
            ret_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign busy      = (state_q != ST_IDLE);
    assign cmd_done  = (state_q == ST_DONE);
    assign cmd_abort = (state_q == ST_DONE) && abort_q;
    assign ret_load  = (state_q == ST_DONE) && ret_q;
    assign ret_low   = ret_low_q;
    assign ret_high  = ret_high_q;
    assign flush_req = (state_q == ST_FLUSH);
    assign feat      = feat_q;
    assign iordy_en  = !feat_q.iordy_off ||
                       (feat_q.pio_mode >= set_features_pkg::PIO_IORDY_MIN);
    assign io16_n    = !(data_access && !feat_q.eight_bit);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_abort_unknown: assert property (
        take && bad |=> cmd_done && cmd_abort)
        else $error("unknown subcommand not aborted");

    a_abort_keep: assert property (
        take && bad |=> cmd_abort && $stable(feat))
        else $error("aborted command changed feature state");

    a_done_pulse: assert property (
        cmd_done |=> !cmd_done && !busy)
        else $error("completion lasted more than one cycle");

    a_io16_eight: assert property (
        feat.eight_bit && data_access |-> io16_n)
        else $error("16-bit indication asserted in 8-bit mode");

    a_flush_first: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_WCACHE_OFF
        |=> flush_req && !cmd_done)
        else $error("cache disable completed without flush");

    a_flush_hold: assert property (
        flush_req && !flush_ack |=> flush_req && !cmd_done)
        else $error("flush request dropped before acknowledge");

    a_pio_accept: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_XFER_MODE &&
        xtype == set_features_pkg::XT_PIO_FLOW && xmode <= PIO_MAX_MODE
        |=> cmd_done && !cmd_abort && feat.pio_mode == $past(xmode))
        else $error("supported PIO mode refused");

    a_iordy_pio3: assert property (
        feat.pio_mode >= 3'h3 |-> iordy_en)
        else $error("IORDY off at PIO mode 3 or above");

    a_udma_excl: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_XFER_MODE &&
        xtype == set_features_pkg::XT_MDMA && xmode <= MDMA_MAX_MODE
        |=> !feat.dma_udma)
        else $error("multiword DMA left Ultra DMA enabled");

    a_mdma_excl: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_XFER_MODE &&
        xtype == set_features_pkg::XT_UDMA && xmode <= UDMA_MAX_MODE
        |=> feat.dma_udma && feat.dma_mode == $past(xmode))
        else $error("Ultra DMA left multiword DMA enabled");

    a_apm_reserved: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_APM_ON &&
        cmd_tf.param == 8'hFF |=> cmd_abort && $stable(feat.apm_level))
        else $error("reserved power level accepted");

    a_limit_return: assert property (
        take && cmd_tf.subcommand == set_features_pkg::SF_CUR_LIMIT
        |=> ret_load && ret_low == CUR_MIN && ret_high == CUR_MAX && !cmd_abort)
        else $error("current limit range not returned");

    a_ret_only_limit: assert property (
        ret_load |-> cmd_done && !cmd_abort)
        else $error("range returned outside a current limit completion");

    a_soft_revert: assert property (
        soft_rst && feat.revert_en && !busy && !take
        |=> feat == set_features_pkg::FEAT_DEFAULT)
        else $error("soft reset did not restore defaults");

    c_flush_done: cover property (flush_req ##1 flush_req ##1 cmd_done);
    c_udma_set: cover property (take ##1 cmd_done && !cmd_abort && feat.dma_udma);
    c_abort_seen: cover property (cmd_done && cmd_abort);
    c_limit_seen: cover property (ret_load);

endmodule : set_features_handler

// ==== test/host_model.sv ====
// host controller model: command strobes and flush acknowledges
module host_model (
    input  wire logic                    core_clk,
    input  wire logic                    flush_req,
    input  wire logic [3:0]              ack_lag,
    output logic                         cmd_valid,
    output set_features_pkg::task_file_t cmd_tf,
    output logic                         flush_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_tf    = '0;
        flush_ack = 1'b0;
    end
    // one-cycle command strobe, task file inverted after it
    task automatic send(input logic [7:0] sub, input logic [7:0] prm);
        @(posedge core_clk) #1;
        cmd_valid = 1'b1;
        cmd_tf    = {set_features_pkg::OPC_SET_FEATURES, sub, prm};
        @(posedge core_clk) #1;
        cmd_valid = 1'b0;
        cmd_tf    = ~cmd_tf;
    endtask : send
    // flush acknowledge after ack_lag cycles
    always @(posedge core_clk)
        if (flush_req && !flush_ack)
        begin
            repeat (ack_lag) @(posedge core_clk);
            #1 flush_ack = 1'b1;
            @(posedge core_clk) #1 flush_ack = 1'b0;
        end
endmodule : host_model

// ==== test/test_set_features_handler.sv ====
// self-checking bench for the set-features handler
module test_set_features_handler;
    timeunit 1ns;
    timeprecision 100ps;
    logic                         core_clk = 1'b0;
    logic                         sys_rst = 1'b1;
    logic                         soft_rst = 1'b0;
    logic                         data_access = 1'b0;
    logic [3:0]                   ack_lag = 4'h0;
    logic                         cmd_valid, flush_ack, busy, cmd_done, cmd_abort, ret_load;
    logic                         flush_req, iordy_en, io16_n;
    logic [7:0]                   ret_low, ret_high;
    set_features_pkg::task_file_t cmd_tf;
    set_features_pkg::feat_t      feat;
    int                           errors = 0;
    int                           n_tests = 0;
    int                           lat;
    always #25 core_clk = ~core_clk;
    host_model u_host_model (.core_clk(core_clk), .flush_req(flush_req), .ack_lag(ack_lag),
        .cmd_valid(cmd_valid), .cmd_tf(cmd_tf), .flush_ack(flush_ack));
    set_features_handler u_set_features_handler (.core_clk(core_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_tf(cmd_tf), .soft_rst(soft_rst), .flush_ack(flush_ack),
        .data_access(data_access), .busy(busy), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
        .ret_load(ret_load), .ret_low(ret_low), .ret_high(ret_high), .flush_req(flush_req),
        .iordy_en(iordy_en), .io16_n(io16_n), .feat(feat));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic run_cmd(input logic [7:0] sub, input logic [7:0] prm, input logic ab);
        lat = 0;
        u_host_model.send(sub, prm);
        while (cmd_done !== 1'b1 && lat < 40)
        begin
            @(posedge core_clk) #1;
            lat++;
        end
        if (lat >= 40)
        begin
            errors++;
            $display("[FAIL] %0t ns: no completion", $time);
        end
        check(8'(busy), 8'h01);
        check(8'(cmd_abort), 8'(ab));
    endtask : run_cmd
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_eight_bit();
        check(8'(feat !== set_features_pkg::FEAT_DEFAULT), 8'h00);
        data_access = 1'b1;
        run_cmd(8'h01, 8'h00, 1'b0);
        check(8'(io16_n), 8'h01);
        run_cmd(8'h81, 8'h00, 1'b0);
        check(8'(io16_n), 8'h00);
    endtask : s_eight_bit
    task automatic s_modes();
        run_cmd(8'h03, 8'h01, 1'b0);
        check(8'({feat.pio_mode, feat.iordy_off, iordy_en}), 8'h02);
        run_cmd(8'h03, 8'h0C, 1'b0);
        check(8'({feat.pio_mode, iordy_en}), 8'h09);
        run_cmd(8'h03, 8'h46, 1'b0);
        check(8'({feat.dma_udma, feat.dma_mode}), 8'h0E);
        run_cmd(8'h03, 8'h22, 1'b0);
        check(8'({feat.dma_udma, feat.dma_mode}), 8'h02);
        run_cmd(8'h03, 8'h12, 1'b1);
        check(8'({feat.dma_udma, feat.dma_mode}), 8'h02);
    endtask : s_modes
    task automatic s_power();
        run_cmd(8'h05, 8'h00, 1'b1);
        run_cmd(8'h05, 8'hFF, 1'b1);
        run_cmd(8'h05, 8'h80, 1'b0);
        check(8'({feat.apm_en, feat.apm_level[6:0]}), 8'h80);
        run_cmd(8'h85, 8'h00, 1'b0);
        check(8'(feat.apm_en), 8'h00);
        run_cmd(8'h9A, 8'h06, 1'b0);
        check(8'(ret_load), 8'h01);
        check(ret_low, 8'h01);
        check(ret_high, 8'hFF);
        check(feat.cur_limit, 8'h06);
        run_cmd(8'h9A, 8'h00, 1'b0);
        check(feat.cur_limit, 8'h01);
    endtask : s_power
    task automatic s_flush();
        run_cmd(8'h02, 8'h00, 1'b0);
        check(8'(feat.wcache), 8'h01);
        ack_lag = 4'h3;
        run_cmd(8'h82, 8'h00, 1'b0);
        check(8'(lat), 8'(ack_lag + 4'h2));
        check(8'(feat.wcache), 8'h00);
    endtask : s_flush
    task automatic s_codes();
        logic [7:0] nops [6] = '{8'h69, 8'h96, 8'h97, 8'hBB, 8'h89, 8'h8A};
        run_cmd(8'h09, 8'h00, 1'b0);
        run_cmd(8'h0A, 8'h00, 1'b0);
        check(8'({feat.ext_power, feat.pl1_en}), 8'h03);
        foreach (nops[i]) run_cmd(nops[i], 8'h5A, 1'b0);
        check(8'({feat.ext_power, feat.pl1_en}), 8'h00);
        run_cmd(8'h10, 8'h00, 1'b1);
    endtask : s_codes
    task automatic s_soft();
        run_cmd(8'h55, 8'h00, 1'b0);
        run_cmd(8'h66, 8'h00, 1'b0);
        @(posedge core_clk) #1 soft_rst = 1'b1;
        @(posedge core_clk) #1 soft_rst = 1'b0;
        check(8'({feat.lookahead, feat.revert_en}), 8'h00);
        run_cmd(8'hCC, 8'h00, 1'b0);
        @(posedge core_clk) #1 soft_rst = 1'b1;
        @(posedge core_clk) #1 soft_rst = 1'b0;
        check(8'(feat !== set_features_pkg::FEAT_DEFAULT), 8'h00);
    endtask : s_soft
    initial
    begin
        repeat (4) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        s_eight_bit();
        s_modes();
        s_power();
        s_flush();
        s_codes();
        s_soft();
        close_out();
    end
    initial
    begin
        repeat (2000) @(posedge core_clk);
        errors++;
        close_out();
    end
endmodule : test_set_features_handler
